// [verilog/barr_pkg.sv]
// Package: opcodes, phases, field positions and constants for the exec block
package barr_pkg;
    localparam int          BARR_DATA_W     = 8;
    localparam int          BARR_PC_W       = 16;
    localparam logic [3:0]  BARR_NIB_MAX    = 4'h9;
    localparam logic [3:0]  BARR_NIB_ADJ    = 4'h6;
    localparam logic [7:0]  BARR_BYTE_ZERO  = 8'h00;
    localparam logic [15:0] BARR_PC_ZERO    = 16'h0000;
    localparam int          BARR_PCH_LSB    = 8;
    localparam int          BARR_MSB        = 7;

    // Operations handed over by the instruction decoder
    typedef enum logic [1:0] {
        BARR_OP_NONE,
        BARR_OP_DADJ,
        BARR_OP_RLC,
        BARR_OP_RET
    } barr_op_t;

    // Four phases of one instruction cycle
    typedef enum logic [1:0] {
        BARR_Q1,
        BARR_Q2,
        BARR_Q3,
        BARR_Q4
    } barr_phase_t;
endpackage : barr_pkg

// [verilog/barr_phase_if.sv]
// Interface: phase strobes from the phase sequencer to the executor
`timescale 1ns/10ps
interface barr_phase_if;
    barr_pkg::barr_phase_t phase;
    logic                  cycle_end;

    modport src (output phase, output cycle_end);
    modport dst (input phase, input cycle_end);
endinterface : barr_phase_if

// [verilog/barr_phase_gen.sv]
// Phase sequencer: steps Q1..Q4 once per enabled clock
`timescale 1ns/10ps
module barr_phase_gen (
    input  wire logic  clk,
    input  wire logic  sys_rst,
    input  wire logic  phase_en,
    barr_phase_if.src  ph
);
    barr_pkg::barr_phase_t phase_r;
    barr_pkg::barr_phase_t phase_nxt;

    // Next phase, wraps after Q4
    always_comb begin
        phase_nxt = phase_r;
        if (phase_en) begin
            case (phase_r)
                barr_pkg::BARR_Q1: phase_nxt = barr_pkg::BARR_Q2;
                barr_pkg::BARR_Q2: phase_nxt = barr_pkg::BARR_Q3;
                barr_pkg::BARR_Q3: phase_nxt = barr_pkg::BARR_Q4;
                barr_pkg::BARR_Q4: phase_nxt = barr_pkg::BARR_Q1;
                default:           phase_nxt = barr_pkg::BARR_Q1;
            endcase
        end
    end

    // Phase register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_r <= barr_pkg::BARR_Q1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    assign ph.phase     = phase_r;
    assign ph.cycle_end = phase_en && (phase_r == barr_pkg::BARR_Q4);
endmodule : barr_phase_gen

// [verilog/barr_exec.sv]
// Executor for decimal adjust, rotate left through carry and return
`timescale 1ns/10ps
module barr_exec #(
    parameter int DATA_W = barr_pkg::BARR_DATA_W,
    parameter int PC_W   = barr_pkg::BARR_PC_W
) (
    clk,
    sys_rst,
    phase_en,
    op_valid,
    op_code,
    op_sel,
    op_addr,
    op_pc,
    op_ready,
    mem_rd_en,
    mem_rd_addr,
    mem_rd_data,
    mem_wr_en,
    mem_wr_addr,
    mem_wr_data,
    working_register,
    carry_flag,
    digit_carry_flag,
    stack_top_value,
    stack_pop,
    pc_load,
    pc_load_value,
    program_counter_high_latch,
    forced_nop
);
    input  wire logic                  clk;
    input  wire logic                  sys_rst;
    input  wire logic                  phase_en;
    input  wire logic                  op_valid;
    input  wire barr_pkg::barr_op_t    op_code;
    input  wire logic                  op_sel;
    input  wire logic [DATA_W-1:0]     op_addr;
    input  wire logic [PC_W-1:0]       op_pc;
    output logic                       op_ready;
    output logic                       mem_rd_en;
    output logic [DATA_W-1:0]          mem_rd_addr;
    input  wire logic [DATA_W-1:0]     mem_rd_data;
    output logic                       mem_wr_en;
    output logic [DATA_W-1:0]          mem_wr_addr;
    output logic [DATA_W-1:0]          mem_wr_data;
    output logic [DATA_W-1:0]          working_register;
    output logic                       carry_flag;
    input  wire logic                  digit_carry_flag;
    input  wire logic [PC_W-1:0]       stack_top_value;
    output logic                       stack_pop;
    output logic                       pc_load;
    output logic [PC_W-1:0]            pc_load_value;
    output logic [DATA_W-1:0]          program_counter_high_latch;
    output logic                       forced_nop;

    barr_phase_if ph ();

    barr_phase_gen u_phase (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .phase_en (phase_en),
        .ph       (ph.src)
    );

    // Latched instruction and working state
    barr_pkg::barr_op_t    op_r,    op_nxt;
    logic                  sel_r,   sel_nxt;
    logic [DATA_W-1:0]     addr_r,  addr_nxt;
    logic [DATA_W-1:0]     opnd_r,  opnd_nxt;
    logic [DATA_W-1:0]     res_r,   res_nxt;
    logic                  cres_r,  cres_nxt;
    logic [DATA_W-1:0]     working_register_r,  working_register_nxt;
    logic                  c_r,     c_nxt;
    logic [DATA_W-1:0]     pch_r,   pch_nxt;
    logic                  nop_r,   nop_nxt;
    logic                  wr_r,    wr_nxt;
    logic [DATA_W-1:0]     wdat_r,  wdat_nxt;
    logic                  pop_r,   pop_nxt;
    logic [PC_W-1:0]       pcv_r,   pcv_nxt;

    // Decimal adjust datapath, five bits per nibble keep the overflow
    logic [4:0]            lo_sum;
    logic [4:0]            hi_sum;
    logic                  lo_fix;
    logic                  hi_fix;
    logic [DATA_W-1:0]     dadj_val;
    logic                  dadj_c;

    always_comb begin
        lo_fix = (working_register_r[3:0] > barr_pkg::BARR_NIB_MAX) || digit_carry_flag;
        lo_sum = {1'b0, working_register_r[3:0]} + (lo_fix ? {1'b0, barr_pkg::BARR_NIB_ADJ} : 5'h00);
        hi_fix = (working_register_r[7:4] > barr_pkg::BARR_NIB_MAX) || c_r;
        hi_sum = {1'b0, working_register_r[7:4]} + (hi_fix ? {1'b0, barr_pkg::BARR_NIB_ADJ} : 5'h00);
        // Low nibble carry does not ripple into the high nibble; each digit fixes alone
        dadj_val = {hi_sum[3:0], lo_sum[3:0]};
        dadj_c   = c_r | hi_sum[4];
    end

    // Phase sequencing of the three instructions
    always_comb begin
        op_nxt   = op_r;
        sel_nxt  = sel_r;
        addr_nxt = addr_r;
        opnd_nxt = opnd_r;
        res_nxt  = res_r;
        cres_nxt = cres_r;
        working_register_nxt = working_register_r;
        c_nxt    = c_r;
        pch_nxt  = pch_r;
        nop_nxt  = nop_r;
        wr_nxt   = 1'b0;
        wdat_nxt = wdat_r;
        pop_nxt  = 1'b0;
        pcv_nxt  = pcv_r;
        if (phase_en) begin
            case (ph.phase)
                barr_pkg::BARR_Q1: begin
                    // Decode; a pending return turns this cycle into a nop
                    if (nop_r) begin
                        op_nxt = barr_pkg::BARR_OP_NONE;
                    end else if (op_valid) begin
                        op_nxt   = op_code;
                        sel_nxt  = op_sel;
                        addr_nxt = op_addr;
                        if (op_code == barr_pkg::BARR_OP_RET) begin
                            pcv_nxt = op_pc;
                        end
                    end else begin
                        op_nxt = barr_pkg::BARR_OP_NONE;
                    end
                end
                barr_pkg::BARR_Q2: begin
                    // Operand read; return latches the high pc byte
                    opnd_nxt = mem_rd_data;
                    if (op_r == barr_pkg::BARR_OP_RET) begin
                        pch_nxt = pcv_r[PC_W-1:barr_pkg::BARR_PCH_LSB];
                    end
                end
                barr_pkg::BARR_Q3: begin
                    // Execute
                    case (op_r)
                        barr_pkg::BARR_OP_DADJ: begin
                            res_nxt  = dadj_val;
                            cres_nxt = dadj_c;
                        end
                        barr_pkg::BARR_OP_RLC: begin
                            res_nxt  = {opnd_r[DATA_W-2:0], c_r};
                            cres_nxt = opnd_r[barr_pkg::BARR_MSB];
                        end
                        barr_pkg::BARR_OP_RET: begin
                            pcv_nxt = stack_top_value;
                            pop_nxt = 1'b1;
                            nop_nxt = 1'b1;
                        end
                        default: begin
                            res_nxt = res_r;
                        end
                    endcase
                end
                barr_pkg::BARR_Q4: begin
                    // Write back; return touches no flag
                    case (op_r)
                        barr_pkg::BARR_OP_DADJ: begin
                            wr_nxt   = 1'b1;
                            wdat_nxt = res_r;
                            c_nxt    = cres_r;
                            if (!sel_r) begin
                                working_register_nxt = res_r;
                            end
                        end
                        barr_pkg::BARR_OP_RLC: begin
                            c_nxt = cres_r;
                            if (sel_r) begin
                                wr_nxt   = 1'b1;
                                wdat_nxt = res_r;
                            end else begin
                                working_register_nxt = res_r;
                            end
                        end
                        default: begin
                            nop_nxt = (op_r == barr_pkg::BARR_OP_RET);
                        end
                    endcase
                end
                default: begin
                    op_nxt = op_r;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op_r   <= barr_pkg::BARR_OP_NONE;
            sel_r  <= 1'b0;
            addr_r <= barr_pkg::BARR_BYTE_ZERO;
            opnd_r <= barr_pkg::BARR_BYTE_ZERO;
            res_r  <= barr_pkg::BARR_BYTE_ZERO;
            cres_r <= 1'b0;
            working_register_r <= barr_pkg::BARR_BYTE_ZERO;
            c_r    <= 1'b0;
            pch_r  <= barr_pkg::BARR_BYTE_ZERO;
            nop_r  <= 1'b0;
            wr_r   <= 1'b0;
            wdat_r <= barr_pkg::BARR_BYTE_ZERO;
            pop_r  <= 1'b0;
            pcv_r  <= barr_pkg::BARR_PC_ZERO;
        end else begin
            op_r   <= op_nxt;
            sel_r  <= sel_nxt;
            addr_r <= addr_nxt;
            opnd_r <= opnd_nxt;
            res_r  <= res_nxt;
            cres_r <= cres_nxt;
            working_register_r <= working_register_nxt;
            c_r    <= c_nxt;
            pch_r  <= pch_nxt;
            nop_r  <= (phase_en && ph.phase == barr_pkg::BARR_Q1) ? 1'b0 : nop_nxt;
            wr_r   <= wr_nxt;
            wdat_r <= wdat_nxt;
            pop_r  <= pop_nxt;
            pcv_r  <= pcv_nxt;
        end
    end

    // Outputs; pops and loads are one-clock pulses after execute
    assign op_ready                   = phase_en && (ph.phase == barr_pkg::BARR_Q1) && !nop_r;
    assign mem_rd_en                  = (ph.phase == barr_pkg::BARR_Q2);
    assign mem_rd_addr                = addr_r;
    assign mem_wr_en                  = wr_r;
    assign mem_wr_addr                = addr_r;
    assign mem_wr_data                = wdat_r;
    assign working_register           = working_register_r;
    assign carry_flag                 = c_r;
    assign stack_pop                  = pop_r;
    assign pc_load                    = pop_r;
    assign pc_load_value              = pcv_r;
    assign program_counter_high_latch = pch_r;
    assign forced_nop                 = nop_r;
endmodule : barr_exec

// [tb/barr_exec_assertions.sv]
// Checker: phase timing and result relations at the executor ports
`timescale 1ns/10ps
module barr_exec_assertions #(
    parameter int DATA_W = barr_pkg::BARR_DATA_W,
    parameter int PC_W   = barr_pkg::BARR_PC_W
) (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               phase_en,
    input wire logic               op_valid,
    input wire barr_pkg::barr_op_t op_code,
    input wire logic               op_sel,
    input wire logic [DATA_W-1:0]  op_addr,
    input wire logic [PC_W-1:0]    op_pc,
    input wire logic               op_ready,
    input wire logic               mem_rd_en,
    input wire logic [DATA_W-1:0]  mem_rd_addr,
    input wire logic [DATA_W-1:0]  mem_rd_data,
    input wire logic               mem_wr_en,
    input wire logic [DATA_W-1:0]  mem_wr_addr,
    input wire logic [DATA_W-1:0]  mem_wr_data,
    input wire logic [DATA_W-1:0]  working_register,
    input wire logic               carry_flag,
    input wire logic [PC_W-1:0]    stack_top_value,
    input wire logic               stack_pop,
    input wire logic               pc_load,
    input wire logic [PC_W-1:0]    pc_load_value,
    input wire logic [DATA_W-1:0]  program_counter_high_latch,
    input wire logic               forced_nop
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Taken operation; the phase_en runs limit checks to takes with no stalled phase, so fixed delays stay exact
    wire   take = op_ready && op_valid && phase_en;

    AST_RD_Q2: assert property (take |=> mem_rd_en && mem_rd_addr == $past(op_addr))
        else $error("operand read not in second phase");
    AST_DADJ_WR: assert property (take && op_code == barr_pkg::BARR_OP_DADJ ##1 phase_en[*3]
        |=> mem_wr_en && mem_wr_addr == $past(op_addr, 4)) else $error("adjust write missing");
    AST_DADJ_COPY: assert property (take && op_code == barr_pkg::BARR_OP_DADJ && !op_sel
        ##1 phase_en[*3] |=> working_register == mem_wr_data) else $error("adjust copy wrong");
    AST_DADJ_CKEEP: assert property (take && op_code == barr_pkg::BARR_OP_DADJ && carry_flag
        ##1 phase_en[*3] |=> carry_flag) else $error("adjust cleared carry");
    AST_RLC_DEST: assert property (take && op_code == barr_pkg::BARR_OP_RLC ##1 phase_en[*3]
        |=> mem_wr_en == $past(op_sel, 4)) else $error("rotate destination wrong");
    AST_RLC_CARRY: assert property (take && op_code == barr_pkg::BARR_OP_RLC ##1 phase_en[*3]
        |=> carry_flag == $past(mem_rd_data[7], 3)) else $error("rotate carry out wrong");
    AST_RET_POP: assert property (take && op_code == barr_pkg::BARR_OP_RET ##1 phase_en[*2]
        |=> stack_pop && pc_load && pc_load_value == $past(stack_top_value))
        else $error("return pop wrong");
    AST_RET_LATCH: assert property (take && op_code == barr_pkg::BARR_OP_RET ##1 phase_en[*2]
        |=> program_counter_high_latch == 8'($past(op_pc, 3) >> barr_pkg::BARR_PCH_LSB))
        else $error("high latch not refreshed");
    AST_RET_NOP: assert property (stack_pop |=> forced_nop && !op_ready)
        else $error("no forced nop after return");
    AST_WR_PULSE: assert property (mem_wr_en |=> !mem_wr_en)
        else $error("write strobe longer than one clock");
endmodule : barr_exec_assertions

bind barr_exec barr_exec_assertions #(.DATA_W(DATA_W), .PC_W(PC_W)) i_chk (.*);

// [tb/barr_exec_tb_top.sv]
// Testbench: adjust, rotate and return scenarios for the executor
`timescale 1ns/10ps
module barr_exec_tb_top;
    logic               clk, sys_rst, phase_en, op_valid, op_sel, digit_carry_flag;
    logic               op_ready, mem_rd_en, mem_wr_en, carry_flag, stack_pop, pc_load;
    logic               forced_nop, c_m;
    barr_pkg::barr_op_t op_code;
    logic [7:0]         op_addr, mem_rd_data, mem_rd_addr, mem_wr_addr, mem_wr_data, w_m;
    logic [7:0]         working_register, program_counter_high_latch;
    logic [15:0]        op_pc, stack_top_value, pc_load_value;
    int                 bad_count, n_tests;

    barr_exec i_dut (.*);

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // Holds the offer until a Q1 accepts it; counts cycles waited
    task automatic issue(input barr_pkg::barr_op_t code, input logic sel, input logic [7:0] addr,
                         input logic [7:0] rd, input logic dc, output int waits);
        waits = 0;
        @(posedge clk);
        op_valid         <= 1'b1;
        op_code          <= code;
        op_sel           <= sel;
        op_addr          <= addr;
        mem_rd_data      <= rd;
        digit_carry_flag <= dc;
        do begin
            @(negedge clk);
            waits++;
        end while (op_ready !== 1'b1 && waits < 20);
        @(posedge clk);
        op_valid <= 1'b0;
    endtask : issue

    // Runs an adjust or rotate against the reference model; nibbles adjust without ripple
    task automatic alu_op(input barr_pkg::barr_op_t code, input logic sel, input logic [7:0] addr,
                          input logic [7:0] rd, input logic dc, output int n);
        logic [7:0] r;
        logic [4:0] hi;
        issue(code, sel, addr, rd, dc, n);
        @(negedge clk);
        chk({7'h00, mem_rd_en, mem_rd_addr}, {7'h00, 1'b1, addr});
        if (code == barr_pkg::BARR_OP_RLC) begin
            r = {rd[6:0], c_m};
            c_m = rd[7];
        end else begin
            r[3:0] = (w_m[3:0] > 4'h9 || dc) ? w_m[3:0] + 4'h6 : w_m[3:0];
            hi = {1'b0, w_m[7:4]} + ((w_m[7:4] > 4'h9 || c_m) ? 5'h06 : 5'h00);
            r[7:4] = hi[3:0];
            c_m = c_m | hi[4];
        end
        if (!sel) w_m = r;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(mem_wr_en, code == barr_pkg::BARR_OP_DADJ || sel);
        if (code == barr_pkg::BARR_OP_DADJ || sel) begin
            chk(mem_wr_addr, addr);
            chk(mem_wr_data, r);
        end
        chk(working_register, w_m);
        chk(carry_flag, c_m);
    endtask : alu_op

    task automatic t_reset();
        @(negedge clk);
        chk({mem_wr_en, stack_pop, pc_load, forced_nop, carry_flag, working_register}, 16'h0000);
    endtask : t_reset

    // Both destinations, carry in and carry out of the rotate
    task automatic t_rotate();
        int n;
        alu_op(barr_pkg::BARR_OP_RLC, 1'b0, 8'h10, 8'he6, 1'b0, n);
        alu_op(barr_pkg::BARR_OP_RLC, 1'b1, 8'h11, 8'h52, 1'b1, n);
    endtask : t_rotate

    // Preloads the working register by rotate, then adjusts; nine is the boundary case
    task automatic t_adjust();
        logic [7:0] pre [6] = '{8'h52, 8'h67, 8'hcd, 8'h4c, 8'h04, 8'hd2};
        int         n;
        for (int i = 0; i < 6; i++) begin
            alu_op(barr_pkg::BARR_OP_RLC, 1'b0, 8'h20, pre[i], 1'b0, n);
            alu_op(barr_pkg::BARR_OP_DADJ, i[0], 8'h21, 8'h00, i[1], n);
        end
    endtask : t_adjust

    // Return, then an offer held through the forced nop must wait a full cycle
    task automatic t_return();
        int n;
        issue(barr_pkg::BARR_OP_RET, 1'b0, 8'h00, 8'h00, 1'b0, n);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({stack_pop, pc_load, forced_nop}, 3'b111);
        chk(pc_load_value, stack_top_value);
        chk(program_counter_high_latch, op_pc[15:8]);
        chk({working_register, carry_flag}, {w_m, c_m});
        alu_op(barr_pkg::BARR_OP_RLC, 1'b1, 8'h31, 8'h80, 1'b0, n);
        chk(16'(n), 16'h0005);
    endtask : t_return

    // Main sequence
    initial begin
        sys_rst          = 1'b1;
        phase_en         = 1'b1;
        op_valid         = 1'b0;
        op_code          = barr_pkg::BARR_OP_NONE;
        op_sel           = 1'b0;
        op_addr          = 8'h00;
        op_pc            = 16'ha37c;
        mem_rd_data      = 8'h00;
        digit_carry_flag = 1'b0;
        stack_top_value  = 16'h1b42;
        bad_count        = 0;
        n_tests          = 0;
        w_m              = 8'h00;
        c_m              = 1'b0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_rotate();
        t_adjust();
        t_return();
        end_sim();
    end

    // Watchdog far beyond the roughly 140 cycles the run needs
    initial begin
        #20000;
        bad_count++;
        end_sim();
    end
endmodule : barr_exec_tb_top
